/* verilog/sac_regs.svh */
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
// Contract
// R1 - Serial mode floats parallel data bits 12-15
// R2 - Busy high from start until result latched
// R3 - Host may use busy fall as ready
// R4 - Output bus enabled only while select, read low
// R5 - Serial clock ignored while chip select high
// R6 - Reset input aborts conversion, resets control
// R7 - Power-down finishes conversion, then inhibits
// R8 - Start falling edge holds sample, starts conversion
// R9 - Low-power mode: held start converts after acquisition; code needs fast rate low as well
// R10 - Serial result shifts out MSB first
// R11 - Unfinished serial read at completion: discard, flag
// R12 - After reset: acquire, busy low, await start

// =============================================
// Timing
`define SAC_CLK_NS 5
`define SAC_ACQ_NS 250
`define SAC_CONV_DIV 4
`define SAC_FLAG_CYCLES 4

// =============================================
// Widths and fields
`define SAC_RESULT_BITS 16
`define SAC_HIZ_LSB 12
`define SAC_HIZ_MSB 15
// Synchronised pin vector: idle has start, select and read high
`define SAC_PIN_IDLE 9'h00E

`endif

/* verilog/sac_pkg.sv */
package sac_pkg;
    // Converter sequencing states
    typedef enum logic [1:0] {
        sac_st_acq,
        sac_st_wait,
        sac_st_conv,
        sac_st_done
    } sac_state_t;
endpackage

/* verilog/sac_converter_ctrl.sv */
`timescale 1ns/10ps
`include "sac_regs.svh"

module sac_converter_ctrl
    import sac_pkg::*;
#(
    parameter int DATA_W = `SAC_RESULT_BITS,
    parameter int CONV_DIV = `SAC_CONV_DIV
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic convert_start_n_in,
    input wire logic chip_select_n_in,
    input wire logic read_n_in,
    input wire logic reset_in,
    input wire logic power_down_in,
    input wire logic interface_select_in,
    input wire logic low_power_in,
    input wire logic fast_rate_in,
    input wire logic serial_clock_in,
    input wire logic comparator_in,
    output logic busy_out,
    output logic hold_out,
    output logic power_save_out,
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe_out,
    output logic serial_result_out,
    output logic serial_result_oe_out,
    output logic incomplete_read_flag_out,
    output logic incomplete_read_flag_oe_out
);

    // =============================================
    // Constants
    localparam int ACQ_CYCLES = (`SAC_ACQ_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS;
    localparam int BW = $clog2(DATA_W);
    localparam int AW = $clog2(ACQ_CYCLES + 1);
    localparam int DW = $clog2(CONV_DIV + 1);
    localparam int DONE_MAX = 80;
    localparam logic [BW-1:0] LAST_BIT = BW'(DATA_W - 1);
    localparam logic [AW-1:0] ACQ_LAST = AW'(ACQ_CYCLES - 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(CONV_DIV - 1);
    localparam logic [2:0] FLAG_LEN = 3'(`SAC_FLAG_CYCLES);

    // =============================================
    // Reset release
    logic rst_s1_reg; // First stage, only feeds the second
    logic rst_n_reg; // Design-wide reset copy

    // Release through two flops, assert at once
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // =============================================
    // Pin synchronisers
    logic [8:0] pin_s1_reg; // First stage
    logic [8:0] pin_s2_reg; // Stable copy read by logic
    logic sclk_prev_reg; // Serial clock history for edges
    logic cnv_prev_reg; // Start history for falling edges

    // Every host pin is asynchronous to our clock
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pin_s1_reg <= `SAC_PIN_IDLE;
            pin_s2_reg <= `SAC_PIN_IDLE;
            sclk_prev_reg <= 1'b0;
            cnv_prev_reg <= 1'b1;
        end else begin
            pin_s1_reg <= {reset_in, power_down_in, interface_select_in, low_power_in,
                fast_rate_in, convert_start_n_in, chip_select_n_in, read_n_in,
                serial_clock_in};
            pin_s2_reg <= pin_s1_reg;
            sclk_prev_reg <= pin_s2_reg[0];
            cnv_prev_reg <= pin_s2_reg[3];
        end
    end

    logic sclk_s, rd_n_s, cs_n_s, cnv_n_s, fast_s, lowp_s, sel_s, pd_s, pin_rst;
    assign {pin_rst, pd_s, sel_s, lowp_s, fast_s, cnv_n_s, cs_n_s, rd_n_s, sclk_s} = pin_s2_reg;

    // R8 falling start edge
    logic start_fall;
    assign start_fall = cnv_prev_reg && !cnv_n_s;
    // R5 serial edges only while selected
    logic sclk_rise;
    assign sclk_rise = sclk_s && !sclk_prev_reg && !cs_n_s;
    // Impulse mode: low power high, fast rate low
    logic impulse;
    assign impulse = lowp_s && !fast_s;

    // =============================================
    // Conversion clock divider
    logic [DW-1:0] div_reg; // Divider count
    logic conv_tick; // One-cycle conversion clock enable
    assign conv_tick = (div_reg == DIV_LAST);

    // Free-running; a step may wait up to one divider period
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            div_reg <= '0;
        end else if (conv_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DW'(1);
        end
    end

    // =============================================
    // Result buffer (two entries)
    logic [DATA_W-1:0] fifo_mem [2]; // Storage entries
    logic wr_ptr_reg, rd_ptr_reg; // Entry indices
    logic [1:0] fifo_cnt_reg; // Occupancy
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic push, pop;
    logic [DATA_W-1:0] sar_reg; // Successive approximation word
    logic shift_active_reg; // Serial read under way

    assign fifo_in_ready = (fifo_cnt_reg != 2'h2);
    assign fifo_out_valid = (fifo_cnt_reg != 2'h0);
    // Drain side stalls while a serial read holds the shifter
    assign fifo_out_ready = !shift_active_reg;
    assign push = fifo_in_valid && fifo_in_ready;
    assign pop = fifo_out_valid && fifo_out_ready;

    // Buffer pointers and occupancy; reset empties it
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else if (pin_rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= !wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= !rd_ptr_reg;
            end
            fifo_cnt_reg <= fifo_cnt_reg + 2'(push) - 2'(pop);
        end
    end

    // Entry storage, no reset needed on data
    always_ff @(posedge clock_in) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= sar_reg;
        end
    end

    // =============================================
    // Conversion sequencer
    sac_state_t state_reg; // Sequencer state
    logic [AW-1:0] acq_cnt_reg; // Acquisition timer
    logic [BW-1:0] bit_idx_reg; // Bit under trial
    logic pend_reg; // Start edge seen during acquisition
    logic busy_reg; // Busy flag
    logic acq_end;
    assign acq_end = (state_reg == sac_st_acq) && (acq_cnt_reg == ACQ_LAST);
    assign fifo_in_valid = (state_reg == sac_st_done);

    // One conversion in flight; a start is taken only in the acquisition or wait state
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= sac_st_acq;
            acq_cnt_reg <= '0;
            bit_idx_reg <= '0;
            pend_reg <= 1'b0;
            sar_reg <= '0;
        end else if (pin_rst) begin
            // R6 abort and clear
            state_reg <= sac_st_acq;
            acq_cnt_reg <= '0;
            bit_idx_reg <= '0;
            pend_reg <= 1'b0;
        end else begin
            case (state_reg)
                sac_st_acq: begin
                    // Remember an early start edge
                    if (start_fall) begin
                        pend_reg <= 1'b1;
                    end
                    if (acq_end) begin
                        acq_cnt_reg <= '0;
                        pend_reg <= 1'b0;
                        // R9 held start in impulse mode
                        // R7 no start while powered down
                        if (!pd_s && (pend_reg || start_fall || (impulse && !cnv_n_s))) begin
                            state_reg <= sac_st_conv;
                            bit_idx_reg <= LAST_BIT;
                            sar_reg <= {1'b1, {(DATA_W-1){1'b0}}};
                        end else begin
                            state_reg <= sac_st_wait;
                        end
                    end else begin
                        acq_cnt_reg <= acq_cnt_reg + AW'(1);
                    end
                end
                sac_st_wait: begin
                    // R8 start edge begins conversion
                    if (start_fall && !pd_s) begin
                        state_reg <= sac_st_conv;
                        bit_idx_reg <= LAST_BIT;
                        sar_reg <= {1'b1, {(DATA_W-1){1'b0}}};
                    end
                end
                sac_st_conv: begin
                    // Decide one bit per conversion tick, MSB first
                    if (conv_tick) begin
                        if (!comparator_in) begin
                            sar_reg[bit_idx_reg] <= 1'b0;
                        end
                        if (bit_idx_reg == '0) begin
                            state_reg <= sac_st_done;
                        end else begin
                            sar_reg[bit_idx_reg - BW'(1)] <= 1'b1;
                            bit_idx_reg <= bit_idx_reg - BW'(1);
                        end
                    end
                end
                default: begin
                    // Wait for buffer room, then reacquire
                    if (fifo_in_ready) begin
                        state_reg <= sac_st_acq;
                    end
                end
            endcase
        end
    end

    // Busy set on start, cleared once the word reaches the shifter
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            busy_reg <= 1'b0;
        end else if (pin_rst) begin
            // R12 idle with busy low
            busy_reg <= 1'b0;
        end else if (state_reg == sac_st_conv) begin
            // R2 high through conversion
            busy_reg <= 1'b1;
        end else if (pop) begin
            // R2 low after latching
            busy_reg <= 1'b0;
        end
    end

    // =============================================
    // Output shifter and read error
    logic [DATA_W-1:0] shift_reg; // Serial shift register
    logic [DATA_W-1:0] word_reg; // Parallel result copy
    logic [BW-1:0] bit_cnt_reg; // Serial bits sent
    logic [2:0] flag_cnt_reg; // Error pulse length
    logic flag_reg; // Error flag
    logic abort;
    assign abort = fifo_out_valid && shift_active_reg;

    // New result wins over an unfinished read
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            shift_reg <= '0;
            word_reg <= '0;
            bit_cnt_reg <= '0;
            shift_active_reg <= 1'b0;
        end else if (pin_rst) begin
            bit_cnt_reg <= '0;
            shift_active_reg <= 1'b0;
        end else if (pop) begin
            shift_reg <= fifo_mem[rd_ptr_reg];
            word_reg <= fifo_mem[rd_ptr_reg];
            bit_cnt_reg <= '0;
        end else if (abort) begin
            // R11 drop the partial read
            shift_active_reg <= 1'b0;
            bit_cnt_reg <= '0;
        end else if (sclk_rise && sel_s) begin
            // R10 shift MSB first on serial clock
            shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
            if (bit_cnt_reg == LAST_BIT) begin
                shift_active_reg <= 1'b0;
                bit_cnt_reg <= '0;
            end else begin
                shift_active_reg <= 1'b1;
                bit_cnt_reg <= bit_cnt_reg + BW'(1);
            end
        end
    end

    // Fixed-length error pulse
    always_ff @(posedge clock_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            flag_cnt_reg <= '0;
            flag_reg <= 1'b0;
        end else if (abort) begin
            // R11 pulse the error flag
            flag_cnt_reg <= FLAG_LEN - 3'(1);
            flag_reg <= 1'b1;
        end else if (flag_cnt_reg != '0) begin
            flag_cnt_reg <= flag_cnt_reg - 3'(1);
        end else begin
            flag_reg <= 1'b0;
        end
    end

    // =============================================
    // Pin drive
    logic bus_en;
    // R4 enable only with select and read low
    assign bus_en = !cs_n_s && !rd_n_s;
    assign busy_out = busy_reg;
    assign hold_out = (state_reg == sac_st_conv) || (state_reg == sac_st_done);
    // R7 reduced power once idle
    assign power_save_out = pd_s && !hold_out;
    assign data_out = word_reg;
    // R1 whole parallel bus, upper nibble included, floats in serial mode
    assign data_oe_out = (bus_en && !sel_s) ? '1 : '0;
    assign serial_result_out = shift_reg[DATA_W-1];
    assign serial_result_oe_out = bus_en && sel_s;
    assign incomplete_read_flag_out = flag_reg;
    assign incomplete_read_flag_oe_out = sel_s;

    // =============================================
    // Assertions
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_reg || pin_rst);

    sequence s_start;
        (state_reg == sac_st_wait) && start_fall && !pd_s;
    endsequence
    sequence s_abort;
        abort && !pin_rst;
    endsequence

    property p_busy_start;
        // Busy is registered from the conversion state, so it shows one cycle after hold
        s_start |=> ##1 busy_out [*2];
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised"); // R2

    property p_hold_start;
        s_start |=> hold_out && (state_reg == sac_st_conv);
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("no hold on start"); // R8

    property p_upper_float;
        sel_s |-> (data_oe_out[`SAC_HIZ_MSB:`SAC_HIZ_LSB] == 4'h0);
    endproperty
    a_upper_float: assert property (p_upper_float) else $error("upper bits driven"); // R1

    property p_bus_enable;
        ((data_oe_out != '0) || serial_result_oe_out) |-> (!cs_n_s && !rd_n_s);
    endproperty
    a_bus_enable: assert property (p_bus_enable) else $error("bus driven unselected"); // R4

    property p_sclk_gate;
        cs_n_s && !pop && !abort |=> $stable(bit_cnt_reg);
    endproperty
    a_sclk_gate: assert property (p_sclk_gate) else $error("shift while deselected"); // R5

    property p_reset_abort;
        @(posedge clock_in) disable iff (!rst_n_reg)
        pin_rst |=> (state_reg == sac_st_acq) && !busy_out;
    endproperty
    a_reset_abort: assert property (p_reset_abort) else $error("reset not aborting"); // R6

    property p_pd_finish;
        (state_reg == sac_st_conv) && pd_s |-> ##[1:DONE_MAX] (state_reg == sac_st_done);
    endproperty
    a_pd_finish: assert property (p_pd_finish) else $error("conversion not finished"); // R7

    property p_pd_inhibit;
        pd_s && (state_reg == sac_st_wait) |=> (state_reg != sac_st_conv);
    endproperty
    a_pd_inhibit: assert property (p_pd_inhibit) else $error("start while powered down"); // R7

    property p_impulse_hold;
        acq_end && impulse && !cnv_n_s && !pd_s |=> (state_reg == sac_st_conv);
    endproperty
    a_impulse_hold: assert property (p_impulse_hold) else $error("held start ignored"); // R9

    property p_msb_first;
        pop |=> (serial_result_out == word_reg[DATA_W-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("MSB not first"); // R10

    property p_read_error;
        // Later link edges of the cut frame may restart the shifter, so look at once
        s_abort |=> (incomplete_read_flag_out && !shift_active_reg)
            ##1 incomplete_read_flag_out [*3] ##1 !incomplete_read_flag_out;
    endproperty
    a_read_error: assert property (p_read_error) else $error("read error not pulsed"); // R11

    property p_reset_idle;
        @(posedge clock_in) disable iff (!rst_n_reg)
        $fell(pin_rst) |-> (state_reg == sac_st_acq) && !busy_out && !hold_out;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset"); // R12

endmodule

/* verification/sac_host_reader.sv */
`timescale 1ns/10ps

// =============================================
// Host model: reads results over the serial or parallel port
module sac_host_reader (
    input wire logic go_in,
    input wire logic cs_high_in,
    input wire logic [4:0] edges_in,
    input wire logic serial_result_in,
    output logic chip_select_n_out,
    output logic read_n_out,
    output logic serial_clock_out,
    output logic [15:0] word_out,
    output logic active_out
);
    // Idle: deselected, link clock parked low between frames
    initial begin
        chip_select_n_out = 1'b1;
        read_n_out = 1'b1;
        serial_clock_out = 1'b0;
        word_out = 16'h0000;
        active_out = 1'b0;
    end

    // One frame per go pulse; cs_high_in sends edges while deselected
    // select and read low
    always @(posedge go_in) begin
        active_out = 1'b1;
        word_out = 16'h0000;
        chip_select_n_out = cs_high_in;
        read_n_out = cs_high_in;
        // Odd delay keeps the first link edge off the system clock edges
        #101;
        for (int i = 0; i < int'(edges_in); i++) begin
            // Sample just before the rise; the bit moved on the third clock edge after the previous rise
            word_out = {word_out[14:0], serial_result_in};
            serial_clock_out = 1'b1;
            #32;
            serial_clock_out = 1'b0;
            #32;
        end
        #20;
        chip_select_n_out = 1'b1;
        read_n_out = 1'b1;
        active_out = 1'b0;
    end
endmodule

/* verification/tb.sv */
`timescale 1ns/10ps
`include "sac_regs.svh"

module tb;
    // =============================================
    // Stimulus and observed signals
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic start_n = 1'b1, reset_in = 1'b0, pd = 1'b0, iface = 1'b0;
    logic low_power = 1'b0, fast_rate = 1'b0, comparator = 1'b0;
    logic go = 1'b0, cs_high = 1'b0;
    logic [4:0] edges = 5'h00;
    logic cs_n, rd_n, sclk, busy, hold, psave, sdo, sdo_oe, flag, flag_oe, active;
    logic [15:0] data, data_oe, word;
    int miscompares = 0, tests_run = 0, flag_cnt = 0, n = 0;
    // Row: serial mode, comparator high span, mask, expected masked word
    typedef struct {logic ser; int split; logic [15:0] mask; logic [15:0] exp;} sac_row_t;
    sac_row_t rows [5] = '{'{1'b0, 0, 16'hFFFF, 16'h0000}, '{1'b0, 80, 16'hFFFF, 16'hFFFF},
        '{1'b1, 24, 16'hF00F, 16'hF000}, '{1'b1, 80, 16'hFFFF, 16'hFFFF},
        '{1'b0, 24, 16'hF00F, 16'hF000}};

    always #2.5 clock_in = ~clock_in;

    sac_converter_ctrl sac_converter_ctrl_i (.clock_in(clock_in), .arst_n_in(arst_n_in),
        .convert_start_n_in(start_n), .chip_select_n_in(cs_n), .read_n_in(rd_n),
        .reset_in(reset_in), .power_down_in(pd), .interface_select_in(iface),
        .low_power_in(low_power), .fast_rate_in(fast_rate), .serial_clock_in(sclk),
        .comparator_in(comparator), .busy_out(busy), .hold_out(hold), .power_save_out(psave),
        .data_out(data), .data_oe_out(data_oe), .serial_result_out(sdo),
        .serial_result_oe_out(sdo_oe), .incomplete_read_flag_out(flag),
        .incomplete_read_flag_oe_out(flag_oe));

    sac_host_reader sac_host_reader_i (.go_in(go), .cs_high_in(cs_high), .edges_in(edges),
        .serial_result_in(sdo), .chip_select_n_out(cs_n), .read_n_out(rd_n),
        .serial_clock_out(sclk), .word_out(word), .active_out(active));

    // Counts cycles with the read-error flag high
    always @(posedge clock_in) if (flag === 1'b1) flag_cnt <= flag_cnt + 1;

    // =============================================
    // Compare, wait and transfer tasks
    task chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clock_in);
    endtask

    // Bounded wait for busy to reach a level
    task wait_busy(input logic val);
        n = 0;
        while (busy !== val && n < 400) begin
            @(posedge clock_in);
            n++;
        end
        chk_bit("busy", val, busy);
    endtask

    // Comparator keeps trial bits for split cycles after busy rises
    task convert(input int split);
        comparator <= (split != 0);
        start_n <= 1'b0;
        wait_busy(1'b1);
        chk_bit("hold", 1'b1, hold);
        start_n <= 1'b1;
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(posedge clock_in);
            n++;
            if (n == split) comparator <= 1'b0;
        end
        chk_bit("busy", 1'b0, busy);
    endtask

    // Host read frame, enables checked while a selected frame is open
    task read(input logic noise, input logic [4:0] e);
        cs_high <= noise;
        edges <= e;
        // Frame settings settle a cycle before the host model wakes
        cyc(1);
        go <= 1'b1;
        cyc(15);
        go <= 1'b0;
        if (!noise) begin
            chk_word("data_oe", iface ? 16'h0000 : 16'hFFFF, data_oe);
            chk_bit("serial_oe", iface, sdo_oe);
        end
        while (active === 1'b1) cyc(1);
        cyc(5);
        chk_word("data_oe idle", 16'h0000, data_oe);
        chk_bit("serial_oe idle", 1'b0, sdo_oe);
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog: the sequence needs roughly 15 us
    initial begin
        #80000;
        miscompares++;
        close_out;
    end

    // =============================================
    // Main sequence
    initial begin
        cyc(4);
        arst_n_in <= 1'b1;
        cyc(60);
        chk_bit("busy after reset", 1'b0, busy);
        foreach (rows[i]) begin
            iface <= rows[i].ser;
            cyc(5);
            flag_cnt = 0;
            convert(rows[i].split);
            chk_word("data", rows[i].exp, data & rows[i].mask);
            read(1'b0, rows[i].ser ? 5'd16 : 5'd0);
            if (rows[i].ser) chk_word("serial word", rows[i].exp, word & rows[i].mask);
            chk_word("flag count", 16'h0000, 16'(flag_cnt));
            cyc(60);
            $display("row %0d done", i);
        end
        // Unselected link edges must not shift the result
        iface <= 1'b1;
        convert(24);
        read(1'b1, 5'd5);
        read(1'b0, 5'd16);
        chk_word("gated word", 16'hF000, word & 16'hF00F);
        $display("gating done");
        // New result lands during an unfinished serial read
        cyc(60);
        flag_cnt = 0;
        fork
            read(1'b0, 5'd16);
            begin
                cyc(40);
                convert(80);
            end
        join
        chk_word("flag count", 16'(`SAC_FLAG_CYCLES), 16'(flag_cnt));
        chk_bit("flag_oe", 1'b1, flag_oe);
        $display("read error done");
        // Reset in mid conversion, then a fresh start
        iface <= 1'b0;
        cyc(60);
        start_n <= 1'b0;
        wait_busy(1'b1);
        start_n <= 1'b1;
        cyc(10);
        reset_in <= 1'b1;
        cyc(6);
        chk_bit("busy in reset", 1'b0, busy);
        chk_bit("hold in reset", 1'b0, hold);
        reset_in <= 1'b0;
        cyc(60);
        chk_bit("busy idle", 1'b0, busy);
        convert(80);
        chk_word("data", 16'hFFFF, data);
        $display("reset done");
        // Power-down during a conversion
        cyc(60);
        start_n <= 1'b0;
        wait_busy(1'b1);
        start_n <= 1'b1;
        pd <= 1'b1;
        wait_busy(1'b0);
        cyc(60);
        chk_bit("power save", 1'b1, psave);
        start_n <= 1'b0;
        cyc(4);
        start_n <= 1'b1;
        flag_cnt = 0;
        repeat (80) begin
            @(posedge clock_in);
            if (busy !== 1'b0) flag_cnt = flag_cnt + 1;
        end
        chk_word("busy while down", 16'h0000, 16'(flag_cnt));
        pd <= 1'b0;
        cyc(60);
        $display("power down done");
        // Fast rate high: a held start must wait for a fresh falling edge
        low_power <= 1'b1;
        fast_rate <= 1'b1;
        cyc(5);
        start_n <= 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        flag_cnt = 0;
        repeat (80) begin
            @(posedge clock_in);
            if (busy !== 1'b0) flag_cnt = flag_cnt + 1;
        end
        chk_word("busy held start", 16'h0000, 16'(flag_cnt));
        start_n <= 1'b1;
        $display("held start done");
        // Impulse mode: start held low converts again after acquisition
        fast_rate <= 1'b0;
        cyc(5);
        start_n <= 1'b0;
        wait_busy(1'b1);
        wait_busy(1'b0);
        wait_busy(1'b1);
        start_n <= 1'b1;
        wait_busy(1'b0);
        low_power <= 1'b0;
        $display("impulse done");
        close_out;
    end
endmodule
